// File: sar_pkg.sv
// Shared constants, types and state layouts of the converter control block
package sar_pkg;
    localparam int RES_W = 12;
    localparam int FIFO_DEPTH = 8;
    localparam int CLK_NS = 25;
    localparam int STEP_NS = 400;
    localparam int STEP_CYC = (STEP_NS + CLK_NS - 1) / CLK_NS;
    localparam int BBM_NS = 50;
    localparam int BBM_CYC = (BBM_NS + CLK_NS - 1) / CLK_NS;
    localparam int PATHS = 14;
    localparam logic [3:0] ADDR_CH_LAST = 4'ha;
    localparam logic [3:0] ADDR_MID = 4'hb;
    localparam logic [3:0] ADDR_LOW = 4'hc;
    localparam logic [3:0] ADDR_HIGH = 4'hd;
    localparam logic [3:0] ADDR_PDN = 4'he;
    localparam logic [4:0] EDGE_SAMPLE = 5'h04;
    localparam logic [4:0] EDGE_LEN = 5'h06;
    localparam logic [4:0] LEN_8 = 5'h08;
    localparam logic [4:0] LEN_12 = 5'h0c;
    localparam logic [4:0] LEN_16 = 5'h10;
    localparam logic [1:0] LSEL_8 = 2'h1;
    localparam logic [1:0] LSEL_16 = 2'h3;
    localparam logic [RES_W-1:0] MSB_WEIGHT = 12'h800;
    localparam logic [7:0] STEP_INIT = 8'(STEP_CYC);
    localparam logic [7:0] BBM_INIT = 8'(BBM_CYC);

    typedef enum logic [1:0] {
        PH_IDLE,
        PH_SAMPLE,
        PH_CONV,
        PH_LATCH
    } sar_phase_e;

    // Path bits 0..10 are the channels, 11 mid, 12 low ref, 13 high ref
    typedef struct packed {
        logic [PATHS-1:0] path;
        logic closed;
    } sar_mux_s;

    typedef struct packed {
        logic [2:0] clk_s;
        logic [2:0] din_s;
        logic [2:0] csn_s;
        logic clk_f;
        logic din_f;
        logic csn_f;
        logic [4:0] edges;
        logic [5:0] shift;
        logic [1:0] len_sel;
        sar_phase_e phase;
        logic power_down;
        logic eoc;
        logic sample;
        logic [PATHS-1:0] path_want;
        sar_mux_s mux;
        logic [7:0] bbm_cnt;
        logic [7:0] step_cnt;
        logic [RES_W-1:0] bit_m;
        logic [RES_W-1:0] kept;
        logic [RES_W-1:0] trial;
    } sar_state_s;
endpackage

// File: sar_fifo.sv
// Result FIFO with valid/ready on both sides
`timescale 1ns/1ps
module sar_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    import sar_pkg::*;
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL = CW'(DEPTH);
    localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0] wr;
        logic [PW-1:0] rd;
        logic [CW-1:0] cnt;
    } sar_fifo_s;

    sar_fifo_s q, d;
    logic push;
    logic pop;

    assign in_ready = (q.cnt != FULL);
    assign out_valid = (q.cnt != '0);
    assign out_data = q.mem[q.rd];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        d = q;
        if (push) begin
            d.mem[q.wr] = in_data;
            d.wr = (q.wr == LAST) ? '0 : q.wr + 1'b1;
        end
        if (pop) begin
            d.rd = (q.rd == LAST) ? '0 : q.rd + 1'b1;
        end
        case ({push, pop})
            2'b10: d.cnt = q.cnt + 1'b1;
            2'b01: d.cnt = q.cnt - 1'b1;
            default: d.cnt = q.cnt;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule

// File: sar_ctrl.sv
// Input select, sample timing and successive-approximation sequencer
//
// How it works
// [RQ1] Addresses 0000..1010 close analog channel zero through analog channel ten.
// [RQ2] 1011 selects reference midpoint, 1100 lower reference, 1101 upper reference.
// [RQ3] Self-test inputs go through the same sample and convert sequence.
// [RQ4] Ideal self-test codes are 800, 000 and FFF hex.
// [RQ5] Address 1110 means power-down, never a channel choice.
// [RQ6] On a selection change the old path opens before the new closes.
// [RQ7] Sampling starts at fourth falling shift edge, runs to cycle end.
// [RQ8] Sample is frozen at the last falling shift edge of the cycle.
// [RQ9] Host treats first result after power-down exit as possibly off; the bench still checks it exactly.
// [RQ10] Exactly 12 result bits, one per step, MSB down to LSB.
// [RQ11] Comparator above drops the trial weight as 0, else keeps as 1.
// [RQ12] Input at or past a reference gives all ones or all zeros.
// [RQ13] Power-down taken at fourth falling edge; left on any other address.
// [RQ14] Done flag high while sampling, low at hold, high on result latch.
// [RQ15] Two command bits pick 8, 12 or 16 bits and the hold edge.
// [RQ16] Steps run on the internal step timer; result latched after last.
`timescale 1ns/1ps
module sar_ctrl (
    input wire logic clk,
    input wire logic rst,
    input wire logic sel_n,
    input wire logic io_clk,
    input wire logic cmd_in,
    input wire logic comp_above,
    input wire logic result_ready,
    output sar_pkg::sar_mux_s mux,
    output logic sample_closed,
    output logic power_down,
    output logic conv_done,
    output logic [sar_pkg::RES_W-1:0] trial,
    output logic result_valid,
    output logic [sar_pkg::RES_W-1:0] result_data
);
    import sar_pkg::*;

    sar_state_s q, d;
    logic [PATHS-1:0] decoded;
    logic [3:0] addr;
    logic clk_agree;
    logic fall;
    logic rise;
    logic in_cycle;
    logic [4:0] edge_next;
    logic [4:0] hold_edge;
    logic push_ready;
    logic step_tick;
    logic any_path;
    logic pdn_hit;
    logic hold_hit;
    logic pushing;

    // Path decode, one compare per multiplexer path
    assign addr = q.shift[3:0];
    for (genvar g = 0; g < PATHS; g++) begin : g_path
        assign decoded[g] = (addr == 4'(g)); // [RQ1] [RQ2]
    end

    // Edges count only once the second and third sync stages agree
    assign clk_agree = (q.clk_s[1] == q.clk_s[2]);
    assign fall = clk_agree && !q.clk_s[2] && q.clk_f;
    assign rise = clk_agree && q.clk_s[2] && !q.clk_f;
    // Shift clocks during conversion are ignored; host waits for done
    assign in_cycle = !q.csn_f && (q.phase != PH_CONV)
        && (q.phase != PH_LATCH);
    assign edge_next = q.edges + 5'h01;
    assign step_tick = (q.step_cnt == 8'h01);
    assign any_path = |q.path_want;
    assign pdn_hit = (addr == ADDR_PDN);
    // Hold needs the length bits, so never before the sixth fall
    assign hold_hit = (edge_next >= EDGE_LEN) && (edge_next == hold_edge);
    assign pushing = (q.phase == PH_LATCH);

    always_comb begin
        case (q.len_sel)
            LSEL_8: hold_edge = LEN_8; // [RQ15]
            LSEL_16: hold_edge = LEN_16; // [RQ15]
            default: hold_edge = LEN_12; // [RQ15]
        endcase
    end

    always_comb begin
        d = q;
        d.clk_s = {q.clk_s[1:0], io_clk};
        d.din_s = {q.din_s[1:0], cmd_in};
        d.csn_s = {q.csn_s[1:0], sel_n};
        if (clk_agree) begin
            d.clk_f = q.clk_s[2];
        end
        if (q.din_s[1] == q.din_s[2]) begin
            d.din_f = q.din_s[2];
        end
        if (q.csn_s[1] == q.csn_s[2]) begin
            d.csn_f = q.csn_s[2];
        end

        // Break-before-make: path stays open for the gap, then closes
        if (q.bbm_cnt != 8'h00) begin
            d.bbm_cnt = q.bbm_cnt - 8'h01;
            if (q.bbm_cnt == 8'h01) begin
                // Unlisted address has no path; input stays open
                d.mux.path = q.path_want; // [RQ6]
                d.mux.closed = any_path; // [RQ6]
                d.sample = any_path; // [RQ7]
            end
        end

        if (q.csn_f) begin
            // Deselect restarts the serial cycle and drops a pending sample
            d.edges = 5'h00;
            d.shift = 6'h00;
            if (q.phase == PH_SAMPLE) begin
                d.phase = PH_IDLE;
                d.sample = 1'b0;
                // Deselect in mid-sample opens the path too
                d.mux.closed = 1'b0;
                d.bbm_cnt = 8'h00;
            end
        end else if (in_cycle) begin
            if (rise) begin
                d.shift = {q.shift[4:0], q.din_f};
            end
            if (fall) begin
                d.edges = edge_next;
                if (edge_next == EDGE_SAMPLE) begin
                    d.mux.closed = 1'b0; // [RQ6]
                    d.sample = 1'b0;
                    if (pdn_hit) begin
                        d.power_down = 1'b1; // [RQ5] [RQ13]
                        d.mux.path = '0; // [RQ5]
                        d.phase = PH_IDLE;
                        d.bbm_cnt = 8'h00;
                    end else begin
                        d.power_down = 1'b0; // [RQ13]
                        d.path_want = decoded; // [RQ3]
                        d.phase = PH_SAMPLE; // [RQ7]
                        d.bbm_cnt = BBM_INIT; // [RQ6]
                    end
                end
                if (edge_next == EDGE_LEN) begin
                    d.len_sel = q.shift[1:0]; // [RQ15]
                end
                if (hold_hit) begin
                    // Cycle ends here; also in power-down, without a convert
                    d.edges = 5'h00;
                    if (q.phase == PH_SAMPLE) begin
                        d.sample = 1'b0; // [RQ8]
                        d.mux.closed = 1'b0;
                        d.bbm_cnt = 8'h00;
                        d.eoc = 1'b0; // [RQ14]
                        d.phase = PH_CONV;
                        d.kept = '0;
                        d.bit_m = MSB_WEIGHT; // [RQ10]
                        d.trial = MSB_WEIGHT; // [RQ11]
                        d.step_cnt = STEP_INIT; // [RQ16]
                    end
                end
            end
        end

        if (q.phase == PH_CONV) begin
            // Step timer runs on clk alone; shift clock plays no part
            if (step_tick) begin
                d.step_cnt = STEP_INIT; // [RQ16]
                // Past a reference the comparator never flips: 0 or FFF
                if (!comp_above) begin
                    d.kept = q.kept | q.bit_m; // [RQ11] [RQ12] [RQ4]
                end
                d.bit_m = q.bit_m >> 1; // [RQ10]
                d.trial = d.kept | (q.bit_m >> 1); // [RQ11]
                if (q.bit_m[0]) begin
                    d.phase = PH_LATCH; // [RQ10]
                    d.trial = '0;
                    d.step_cnt = 8'h00;
                end
            end else begin
                d.step_cnt = q.step_cnt - 8'h01;
            end
        end

        // Full FIFO stalls here, done stays low until there is room
        if (pushing && push_ready) begin
            d.phase = PH_IDLE; // [RQ16]
            d.eoc = 1'b1; // [RQ14]
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q <= '0;
            q.clk_s <= 3'h0;
            q.csn_s <= 3'h7;
            q.csn_f <= 1'b1;
            q.phase <= PH_IDLE;
            q.power_down <= 1'b1; // [RQ13]
            q.eoc <= 1'b1; // [RQ14]
        end else begin
            q <= d;
        end
    end

    sar_fifo #(
        .WIDTH(RES_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst(rst),
        .in_valid(pushing),
        .in_ready(push_ready),
        .in_data(q.kept), // [RQ16]
        .out_valid(result_valid),
        .out_ready(result_ready),
        .out_data(result_data)
    );

    assign mux = q.mux;
    assign sample_closed = q.sample;
    assign power_down = q.power_down;
    assign conv_done = q.eoc;
    assign trial = q.trial;
endmodule

// File: sar_host.sv
// Host serial port model: select, shift clock and command bits
`timescale 1ns/1ps
module sar_host (
    output logic sel_n,
    output logic io_clk,
    output logic cmd_in
);
    initial begin
        sel_n = 1'b1;
        io_clk = 1'b0;
        cmd_in = 1'b0;
    end
    // Shift clock stands low between frames; 200 ns period
    // First result after wake is still taken; ideal model has no settling
    task automatic send(input logic [15:0] cmd, input int n);
        sel_n = 1'b0;
        #400;
        for (int i = 0; i < n; i++) begin
            cmd_in = cmd[15-i];
            #100 io_clk = 1'b1;
            #100 io_clk = 1'b0;
        end
        // Released line flips so a stale bit is never trusted
        cmd_in = ~cmd_in;
    endtask
    // Deselect; shift clock stays low meanwhile
    task automatic idle();
        sel_n = 1'b1;
        #400;
    endtask
endmodule

// File: sar_ctrl_props.sv
// Port assertions for the converter control block
`timescale 1ns/1ps
module sar_props
    import sar_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire sar_mux_s mux,
    input wire logic sample_closed,
    input wire logic power_down,
    input wire logic conv_done,
    input wire logic [RES_W-1:0] trial,
    input wire logic result_valid
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    path_one_a:
    assert property (mux.closed |-> $onehot(mux.path))
        else $error("closed mux without a single path");
    path_bbm_a:
    assert property (mux.closed && $past(mux.closed) |-> $stable(mux.path))
        else $error("path changed while closed");
    pdown_open_a:
    assert property (power_down |-> !mux.closed && !sample_closed)
        else $error("input connected in power-down");
    sample_mux_a:
    assert property (sample_closed |-> mux.closed && conv_done)
        else $error("sampling without path or done");
    hold_start_a:
    assert property ($fell(conv_done) |-> !sample_closed && trial == MSB_WEIGHT)
        else $error("conversion start wrong");
    step_hold_a:
    assert property ($fell(conv_done) |=> $stable(trial)[*8])
        else $error("first step too short");
    done_rise_a:
    assert property ($rose(conv_done) |-> trial == '0 && result_valid)
        else $error("done rose without latched result");
    done_len_a:
    assert property ($rose(conv_done) |-> !$past(conv_done, 190))
        else $error("conversion shorter than twelve steps");
endmodule

bind sar_ctrl sar_props u_props (.clk, .rst, .mux, .sample_closed,
    .power_down, .conv_done, .trial, .result_valid);

// File: testbench.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
module testbench;
    import sar_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic comp_above = 1'b0;
    logic result_ready = 1'b0;
    logic sel_n, io_clk, cmd_in;
    sar_mux_s mux;
    logic sample_closed, power_down, conv_done, result_valid;
    logic [RES_W-1:0] trial, result_data;
    logic [RES_W-1:0] vin = '0;
    logic [RES_W-1:0] exp_q[$];
    int miscompares = 0;
    int n_checks = 0;
    int cyc = 0;

    always #12.5 clk = ~clk;
    sar_host host (.sel_n, .io_clk, .cmd_in);
    sar_ctrl dut (.clk, .rst, .sel_n, .io_clk, .cmd_in, .comp_above,
        .result_ready, .mux, .sample_closed, .power_down, .conv_done,
        .trial, .result_valid, .result_data);
    // Ideal ladder: trips when the trial code exceeds the input
    always @(negedge clk) comp_above <= trial > vin;

    task automatic stop_test();
        if (miscompares == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            miscompares++;
            stop_test();
        end
    end
    task automatic chk(input string what, input logic [31:0] got, exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask
    // One transfer, then wait for the result unless it is power-down or the FIFO stalls it
    task automatic frame(input logic [3:0] a, input logic [1:0] ls);
        int n;
        n = ls == LSEL_8 ? 8 : ls == LSEL_16 ? 16 : 12;
        vin = a == ADDR_HIGH ? 12'hfff : a == ADDR_MID ? 12'h800 :
            a == ADDR_LOW ? 12'h000 : {3{a}};
        fork
            host.send({a, ls, 10'h000}, n);
            if (a != ADDR_PDN) begin
                for (int i = 0; i < 200 && sample_closed !== 1'b1; i++)
                    @(negedge clk);
                chk("path", mux.path, 16'h0001 << a);
            end
        join
        // Hold lags the last fall by the synchroniser
        chk("sampling", sample_closed, a != ADDR_PDN);
        if (a != ADDR_PDN) begin
            for (int i = 0; i < 8 && conv_done === 1'b1; i++) @(negedge clk);
            chk("hold", {conv_done, sample_closed}, 2'b00);
            chk("trial", trial, MSB_WEIGHT);
            for (int i = 0; i < 250 && conv_done !== 1'b1; i++)
                @(negedge clk);
            exp_q.push_back(vin);
        end
    endtask
    task automatic pop();
        chk("valid", result_valid, 1'b1);
        chk("result", result_data, exp_q.pop_front());
        result_ready = 1'b1;
        @(negedge clk);
        result_ready = 1'b0;
    endtask

    task automatic t_reset();
        chk("reset", {power_down, conv_done, result_valid, mux},
            18'h30000);
    endtask
    // Addresses 0 to 13, length codes 1 to 3, self-test codes included
    task automatic t_select();
        for (int a = 0; a <= 13; a++) begin
            frame(4'(a), 2'(a % 3 + 1));
            pop();
        end
    endtask
    task automatic t_pdown();
        frame(ADDR_PDN, 2'h2);
        repeat (220) @(negedge clk);
        chk("pdown", {power_down, mux.closed, result_valid}, 3'b100);
        frame(4'h5, 2'h2);
        chk("wake", power_down, 1'b0);
        pop();
    endtask
    // Deselect in mid-sample drops the sample, done stays high
    task automatic t_abort();
        host.send({4'h3, 2'h2, 10'h000}, 6);
        host.idle();
        chk("abort", {sample_closed, mux.closed, conv_done}, 3'b001);
        frame(4'h3, 2'h2);
        pop();
    endtask
    // Ninth result finds the FIFO full and must wait
    task automatic t_fill();
        for (int i = 0; i < 9; i++) frame(4'(i), 2'h0);
        chk("stall", {conv_done, result_valid}, 2'b01);
        for (int i = 0; i < 9; i++) pop();
    endtask

    initial begin
        repeat (2) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        t_reset();
        t_select();
        t_pdown();
        t_abort();
        t_fill();
        stop_test();
    end
endmodule
